// ==== core/ddc_config_regs.sv ====
// Configuration register group: protect response, host link options, scratch memory, broadcast
//
// Notes on behaviour
// - Protect 00: Hi-Z at once; 01: jump to stored code, then Hi-Z.
// - Protect 10/11: slew to margin-low/high code, then Hi-Z power-down.
// - Bus timeout enabled only while the timeout-enable bit is one.
// - Paged bus commands accepted only while the paged-bus enable bit is one.
// - Fast readback timing only while the fast-readback bit is one.
// - Serial read data driven on the pin only while readback-enable is one.
// - Writing the pointer selects the memory word for the next data access.
// - Each write through the data register advances the pointer by one.
// - Data writes store at the pointer; data reads return that word.
// - Outside a protect jump or slew, a broadcast write applies its code to all enabled channels at once.
// - Broadcast code left-aligned: 12 bits voltage mode, 8 bits current mode.
// - Broadcast code is unsigned straight binary.
// - Only channels with broadcast enable set take the broadcast code.
// - Paged bus reaches the four registers on page FFh, commands E9h, EFh, F0h and F1h.
// - Falling edge on the protect input launches the response; high does nothing.
`timescale 1ns/1ns
module ddc_config_regs (
   input  wire logic                                        clk_i,
   input  wire logic                                        reset_i,
   // Register port from the serial front end
   input  wire logic [7:0]                                  reg_addr_i,
   input  wire logic                                        reg_wr_i,
   input  wire logic                                        reg_rd_i,
   input  wire logic [15:0]                                 reg_wdata_i,
   output logic      [15:0]                                 reg_rdata_o,
   output logic                                             reg_rvalid_o,
   output logic                                             reg_err_o,
   // Paged bus command port
   input  wire logic                                        pmb_valid_i,
   input  wire logic                                        pmb_wr_i,
   input  wire logic [7:0]                                  pmb_page_i,
   input  wire logic [7:0]                                  pmb_cmd_i,
   input  wire logic [15:0]                                 pmb_wdata_i,
   output logic                                             pmb_nack_o,
   // Host link controls
   output logic                                             low_power_select_o,
   output logic                                             i2c_timeout_en_o,
   output logic                                             pmbus_en_o,
   output logic                                             fast_readback_enable_o,
   output logic                                             readback_pin_enable_o,
   // General-purpose pin
   input  wire logic                                        gpio_i,
   input  wire logic                                        protect_input_sel_i,
   input  wire logic                                        sdo_active_i,
   input  wire logic                                        sdo_data_i,
   output logic                                             gpio_o,
   output logic                                             gpio_oe_o,
   // Channels
   input  wire logic [ddc_pkg::CHANNELS-1:0]                channel_broadcast_enable_i,
   input  wire logic [ddc_pkg::CHANNELS-1:0]                current_output_mode_i,
   input  wire logic [ddc_pkg::CHANNELS*ddc_pkg::CODE_WIDTH-1:0] nvm_code_i,
   input  wire logic [ddc_pkg::CHANNELS*ddc_pkg::CODE_WIDTH-1:0] margin_low_i,
   input  wire logic [ddc_pkg::CHANNELS*ddc_pkg::CODE_WIDTH-1:0] margin_high_i,
   output logic      [ddc_pkg::CHANNELS*ddc_pkg::CODE_WIDTH-1:0] channel_code_o,
   output logic      [ddc_pkg::CHANNELS-1:0]                channel_hiz_o,
   output logic                                             protect_busy_o
);
   import ddc_pkg::*;

   // ============================================================
   // Registers
   logic [15:0]              operating_mode_settings;
   logic [15:0]              host_link_settings;
   logic [POINTER_WIDTH-1:0] scratch_memory_pointer;
   logic [15:0]              all_channel_code;
   logic [WORD_WIDTH-1:0]    mem_rdata;

   // ============================================================
   // Paged bus command decode
   wire pmb_page_hit  = (pmb_page_i == PMB_CONFIG_PAGE);
   wire pmb_cmd_known = (pmb_cmd_i == PMB_CMD_OPERATING)
                      | (pmb_cmd_i == PMB_CMD_POINTER)
                      | (pmb_cmd_i == PMB_CMD_WORD)
                      | (pmb_cmd_i == PMB_CMD_ALL_CHANNEL);
   wire pmb_accept    = pmb_valid_i & host_link_settings[PMBUS_EN_BIT]
                      & pmb_page_hit & pmb_cmd_known & ~reg_wr_i & ~reg_rd_i;
   wire pmb_refuse    = pmb_valid_i & ~pmb_accept;

   logic [7:0] pmb_offset;
   always_comb begin
      unique case (pmb_cmd_i)
         PMB_CMD_OPERATING:   pmb_offset = OFS_OPERATING_MODE;
         PMB_CMD_POINTER:     pmb_offset = OFS_SCRATCH_POINTER;
         PMB_CMD_WORD:        pmb_offset = OFS_SCRATCH_WORD;
         PMB_CMD_ALL_CHANNEL: pmb_offset = OFS_ALL_CHANNEL_CODE;
         default:             pmb_offset = 8'h00;
      endcase
   end

   // ============================================================
   // Merged access path; the register port wins over the paged port
   wire        acc_wr    = reg_wr_i | (pmb_accept & pmb_wr_i);
   wire        acc_rd    = (reg_rd_i & ~reg_wr_i) | (pmb_accept & ~pmb_wr_i);
   wire [7:0]  acc_addr  = (reg_wr_i | reg_rd_i) ? reg_addr_i : pmb_offset;
   wire [15:0] acc_wdata = reg_wr_i ? reg_wdata_i : pmb_wdata_i;

   wire sel_mode  = (acc_addr == OFS_OPERATING_MODE);
   wire sel_link  = (acc_addr == OFS_HOST_LINK);
   wire sel_ptr   = (acc_addr == OFS_SCRATCH_POINTER);
   wire sel_word  = (acc_addr == OFS_SCRATCH_WORD);
   wire sel_bcast = (acc_addr == OFS_ALL_CHANNEL_CODE);
   wire sel_any   = sel_mode | sel_link | sel_ptr | sel_word | sel_bcast;

   wire wr_mode  = acc_wr & sel_mode;
   wire wr_link  = acc_wr & sel_link;
   wire wr_ptr   = acc_wr & sel_ptr;
   wire wr_word  = acc_wr & sel_word;
   wire wr_bcast = acc_wr & sel_bcast;

   // ============================================================
   // Configuration registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         operating_mode_settings <= OPERATING_MODE_RESET;
         host_link_settings      <= HOST_LINK_RESET;
      end else begin
         if (wr_mode) begin
            operating_mode_settings <= acc_wdata;
         end
         if (wr_link) begin
            host_link_settings <= acc_wdata & HOST_LINK_MASK;
         end
      end
   end

   // ============================================================
   // Scratch memory pointer
   wire [POINTER_WIDTH-1:0] next_pointer = scratch_memory_pointer + 8'h01;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scratch_memory_pointer <= POINTER_RESET;
      end else if (wr_ptr) begin
         scratch_memory_pointer <= acc_wdata[POINTER_WIDTH-1:0];
      end else if (wr_word) begin
         scratch_memory_pointer <= next_pointer;
      end
      // Reads never move the pointer
   end

   ddc_scratch_mem u_mem (
      .clk_i   (clk_i),
      .wr_i    (wr_word),
      .addr_i  (scratch_memory_pointer),
      .wdata_i (acc_wdata),
      .rdata_o (mem_rdata)
   );

   // ============================================================
   // Read answer: two cycles, so a read right after a pointer write
   // sees the newly addressed word
   logic        rd_q;
   logic        rd_err_q;
   logic [15:0] rd_data_q;
   logic        rd_word_q;

   wire [15:0] rd_mux = sel_mode  ? operating_mode_settings :
                        sel_link  ? host_link_settings :
                        sel_ptr   ? {8'h00, scratch_memory_pointer} :
                        sel_bcast ? (all_channel_code & CODE_MASK) :
                                    16'h0000;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_q      <= 1'b0;
         rd_err_q  <= 1'b0;
         rd_word_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end else begin
         rd_q      <= acc_rd;
         rd_err_q  <= acc_rd & ~sel_any;
         rd_word_q <= acc_rd & sel_word;
         rd_data_q <= rd_mux;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rvalid_o <= 1'b0;
         reg_err_o    <= 1'b0;
         reg_rdata_o  <= 16'h0000;
         pmb_nack_o   <= 1'b0;
      end else begin
         reg_rvalid_o <= rd_q;
         reg_err_o    <= rd_err_q | ((reg_wr_i | pmb_accept & pmb_wr_i) & ~sel_any);
         reg_rdata_o  <= rd_word_q ? mem_rdata : rd_data_q;
         pmb_nack_o   <= pmb_refuse;
      end
   end

   // ============================================================
   // Host link controls
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_power_select_o     <= 1'b0;
         i2c_timeout_en_o       <= 1'b0;
         pmbus_en_o             <= 1'b0;
         fast_readback_enable_o <= 1'b0;
         readback_pin_enable_o  <= 1'b0;
         gpio_o                 <= 1'b0;
         gpio_oe_o              <= 1'b0;
      end else begin
         low_power_select_o     <= operating_mode_settings[LOW_POWER_BIT];
         i2c_timeout_en_o       <= host_link_settings[TIMEOUT_EN_BIT];
         pmbus_en_o             <= host_link_settings[PMBUS_EN_BIT];
         fast_readback_enable_o <= host_link_settings[FAST_READBACK_BIT];
         readback_pin_enable_o  <= host_link_settings[READBACK_PIN_BIT];
         gpio_o                 <= host_link_settings[READBACK_PIN_BIT] & sdo_data_i;
         gpio_oe_o              <= host_link_settings[READBACK_PIN_BIT] & sdo_active_i;
      end
   end

   // ============================================================
   // Protect trigger: falling edge of the pin while it serves as protect input
   logic gpio_q;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         gpio_q <= 1'b1;
      end else begin
         gpio_q <= gpio_i;
      end
   end

   wire protect_fall = protect_input_sel_i & gpio_q & ~gpio_i;

   ddc_protect_t    protect_mode;
   ddc_prot_state_t prot_state;
   ddc_prot_state_t next_prot_state;
   logic [3:0]      slew_cnt;

   assign protect_mode = ddc_protect_t'(operating_mode_settings[PROTECT_LSB +: 2]);

   wire slew_tick = (slew_cnt == 4'h0);

   // ============================================================
   // Channel codes and power state
   logic [CODE_WIDTH-1:0] code   [CHANNELS];
   logic [CODE_WIDTH-1:0] target [CHANNELS];
   logic [CHANNELS-1:0]   at_target;
   logic [CHANNELS-1:0]   hiz;

   // Broadcast code, left-aligned unsigned binary per channel mode
   wire [CODE_WIDTH-1:0] bcast_voltage = acc_wdata[15:CODE_LSB];
   wire [CODE_WIDTH-1:0] bcast_current = {acc_wdata[15:8], 4'h0};

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         all_channel_code <= ALL_CHANNEL_RESET;
      end else if (wr_bcast) begin
         all_channel_code <= acc_wdata;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
         wire [CODE_WIDTH-1:0] nvm_c  = nvm_code_i[ch*CODE_WIDTH +: CODE_WIDTH];
         wire [CODE_WIDTH-1:0] low_c  = margin_low_i[ch*CODE_WIDTH +: CODE_WIDTH];
         wire [CODE_WIDTH-1:0] high_c = margin_high_i[ch*CODE_WIDTH +: CODE_WIDTH];
         wire [CODE_WIDTH-1:0] bc     = current_output_mode_i[ch] ? bcast_current
                                                                  : bcast_voltage;
         wire take_bcast = wr_bcast & channel_broadcast_enable_i[ch]
                         & (prot_state inside {PS_IDLE, PS_POWERED_DOWN});
         wire up         = target[ch] > code[ch];

         assign target[ch]    = (protect_mode == PROT_SLEW_HIGH) ? high_c : low_c;
         assign at_target[ch] = (code[ch] == target[ch]);

         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               code[ch] <= CHANNEL_CODE_RESET;
               hiz[ch]  <= 1'b0;
            end else begin
               if (take_bcast) begin
                  code[ch] <= bc;
                  hiz[ch]  <= 1'b0;
               end else if (prot_state == PS_IDLE && protect_fall
                            && protect_mode == PROT_HIZ) begin
                  hiz[ch] <= 1'b1;
               end else if (prot_state == PS_JUMP) begin
                  code[ch] <= nvm_c;
               end else if (prot_state == PS_SLEW && slew_tick && !at_target[ch]) begin
                  code[ch] <= up ? code[ch] + 12'h001 : code[ch] - 12'h001;
               end else if (next_prot_state == PS_POWERED_DOWN) begin
                  hiz[ch] <= 1'b1;
               end
            end
         end

         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               channel_code_o[ch*CODE_WIDTH +: CODE_WIDTH] <= CHANNEL_CODE_RESET;
               channel_hiz_o[ch]                           <= 1'b0;
            end else begin
               channel_code_o[ch*CODE_WIDTH +: CODE_WIDTH] <= code[ch];
               channel_hiz_o[ch]                           <= hiz[ch];
            end
         end
      end
   endgenerate

   // ============================================================
   // Protect sequencer
   always_comb begin
      next_prot_state = prot_state;
      unique case (prot_state)
         PS_IDLE: begin
            if (protect_fall) begin
               unique case (protect_mode)
                  PROT_HIZ:          next_prot_state = PS_POWERED_DOWN;
                  PROT_NVM_THEN_HIZ: next_prot_state = PS_JUMP;
                  PROT_SLEW_LOW,
                  PROT_SLEW_HIGH:    next_prot_state = PS_SLEW;
               endcase
            end
         end
         PS_JUMP: next_prot_state = PS_POWERED_DOWN;
         PS_SLEW: begin
            if (&at_target) begin
               next_prot_state = PS_POWERED_DOWN;
            end
         end
         PS_POWERED_DOWN: begin
            if (wr_bcast) begin
               next_prot_state = PS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prot_state     <= PS_IDLE;
         slew_cnt       <= 4'h0;
         protect_busy_o <= 1'b0;
      end else begin
         prot_state     <= next_prot_state;
         slew_cnt       <= (prot_state != PS_SLEW || slew_tick) ? SLEW_STEP_CYCLES - 4'h1
                                                                : slew_cnt - 4'h1;
         protect_busy_o <= (next_prot_state != PS_IDLE);
      end
   end

endmodule : ddc_config_regs

// ==== core/ddc_pkg.sv ====
// Shared constants for the converter configuration register group
package ddc_pkg;

   // ============================================================
   // Register offsets (register port and config-page commands)
   localparam logic [7:0] OFS_OPERATING_MODE   = 8'h25;
   localparam logic [7:0] OFS_HOST_LINK        = 8'h26;
   localparam logic [7:0] OFS_SCRATCH_POINTER  = 8'h2B;
   localparam logic [7:0] OFS_SCRATCH_WORD     = 8'h2C;
   localparam logic [7:0] OFS_ALL_CHANNEL_CODE = 8'h50;

   localparam logic [7:0] PMB_CONFIG_PAGE      = 8'hFF;
   localparam logic [7:0] PMB_CMD_OPERATING    = 8'hE9;
   localparam logic [7:0] PMB_CMD_POINTER      = 8'hEF;
   localparam logic [7:0] PMB_CMD_WORD         = 8'hF0;
   localparam logic [7:0] PMB_CMD_ALL_CHANNEL  = 8'hF1;

   // ============================================================
   // Field positions
   localparam int LOW_POWER_BIT       = 13;
   localparam int PROTECT_LSB         = 8;
   localparam int TIMEOUT_EN_BIT      = 12;
   localparam int PMBUS_EN_BIT        = 8;
   localparam int FAST_READBACK_BIT   = 2;
   localparam int READBACK_PIN_BIT    = 0;
   localparam int POINTER_WIDTH       = 8;
   localparam int WORD_WIDTH          = 16;
   localparam int CODE_WIDTH          = 12;
   localparam int CURRENT_CODE_WIDTH  = 8;
   localparam int CODE_LSB            = 4;
   localparam int CHANNELS            = 2;
   localparam int MEM_DEPTH           = 256;

   // Writable bits of the host link register
   localparam logic [15:0] HOST_LINK_MASK = 16'h1105;
   localparam logic [15:0] CODE_MASK      = 16'hFFF0;

   // ============================================================
   // Reset values
   localparam logic [15:0] OPERATING_MODE_RESET = 16'h0000;
   localparam logic [15:0] HOST_LINK_RESET      = 16'h0000;
   localparam logic [7:0]  POINTER_RESET        = 8'h00;
   localparam logic [15:0] ALL_CHANNEL_RESET    = 16'h0000;
   localparam logic [11:0] CHANNEL_CODE_RESET   = 12'h000;

   // ============================================================
   // Protect response encodings
   typedef enum logic [1:0] {
      PROT_HIZ         = 2'h0,
      PROT_NVM_THEN_HIZ = 2'h1,
      PROT_SLEW_LOW    = 2'h2,
      PROT_SLEW_HIGH   = 2'h3
   } ddc_protect_t;

   typedef enum logic [1:0] {
      PS_IDLE,
      PS_JUMP,
      PS_SLEW,
      PS_POWERED_DOWN
   } ddc_prot_state_t;

   // Cycles between slew steps of one code
   localparam logic [3:0] SLEW_STEP_CYCLES = 4'h1;
   // Read answer latency in cycles
   localparam int READ_LATENCY = 2;

endpackage : ddc_pkg

// ==== core/ddc_scratch_mem.sv ====
// Scratch memory with registered read data
`timescale 1ns/1ns
module ddc_scratch_mem (
   input  wire logic                                 clk_i,
   input  wire logic                                 wr_i,
   input  wire logic [ddc_pkg::POINTER_WIDTH-1:0]    addr_i,
   input  wire logic [ddc_pkg::WORD_WIDTH-1:0]       wdata_i,
   output logic      [ddc_pkg::WORD_WIDTH-1:0]       rdata_o
);
   import ddc_pkg::*;

   logic [WORD_WIDTH-1:0] mem [MEM_DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end

endmodule : ddc_scratch_mem

// ==== dv/ddc_host.sv ====
// Host model driving the register port and the paged command port
`timescale 1ns/1ns
module ddc_host (
   input  wire logic        clk_i,
   input  wire logic        rvalid_i,
   input  wire logic [15:0] rdata_i,
   input  wire logic        nack_i,
   output logic      [7:0]  addr_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [15:0] wdata_o,
   output logic             pv_o,
   output logic             pwr_o,
   output logic      [7:0]  page_o,
   output logic      [7:0]  cmd_o
);
   initial begin
      {addr_o, wr_o, rd_o, wdata_o, pv_o, pwr_o, page_o, cmd_o} = '0;
   end
   // Released data shows the inverse so a stale value is never read as valid
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      d = 16'hXXXX;
      repeat (4) begin
         @(posedge clk_i);
         if (rvalid_i === 1'b1) d = rdata_i;
      end
   endtask : rd
   task cmd(input logic [7:0] pg, input logic [7:0] c, input logic [15:0] d, output logic nk);
      @(posedge clk_i);
      page_o <= pg;
      cmd_o <= c;
      wdata_o <= d;
      pwr_o <= 1'b1;
      pv_o <= 1'b1;
      @(posedge clk_i);
      pv_o <= 1'b0;
      @(posedge clk_i);
      nk = nack_i;
   endtask : cmd
endmodule : ddc_host

// ==== dv/ddc_config_regs_sva.sv ====
// Port checks of the configuration register group
`timescale 1ns/1ns
module ddc_config_regs_sva (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        reg_rvalid_o,
   input wire logic        reg_err_o,
   input wire logic        pmb_valid_i,
   input wire logic [7:0]  pmb_page_i,
   input wire logic        pmb_nack_o,
   input wire logic        low_power_select_o,
   input wire logic        i2c_timeout_en_o,
   input wire logic        pmbus_en_o,
   input wire logic        fast_readback_enable_o,
   input wire logic        readback_pin_enable_o,
   input wire logic        gpio_i,
   input wire logic        protect_input_sel_i,
   input wire logic        gpio_oe_o,
   input wire logic [1:0]  channel_hiz_o,
   input wire logic        protect_busy_o
);
   logic [1:0] mode;
   wire        mapped = reg_addr_i inside {8'h25, 8'h26, 8'h2B, 8'h2C, 8'h50};
   wire        link_wr = reg_wr_i && reg_addr_i == 8'h26;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ============================================================
   // Last protect response written through the register port
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode <= 2'b00;
      end else if (reg_wr_i && reg_addr_i == 8'h25) begin
         mode <= reg_wdata_i[9:8];
      end
   end
   // ============================================================
   // Assertions
   AST_RVALID: assert property (reg_rd_i && !reg_wr_i |-> ##2 reg_rvalid_o)
      else $error("read answer missing");
   AST_UNMAPPED: assert property (reg_rd_i && !reg_wr_i && !mapped
      |-> ##2 reg_err_o && reg_rdata_o == 16'h0000) else $error("unmapped read");
   AST_LOW_POWER: assert property (reg_wr_i && reg_addr_i == 8'h25
      |-> ##2 low_power_select_o == $past(reg_wdata_i[13], 2)) else $error("low power bit");
   AST_LINK: assert property (link_wr |-> ##2 {i2c_timeout_en_o, fast_readback_enable_o}
      == $past({reg_wdata_i[12], reg_wdata_i[2]}, 2)) else $error("link options");
   AST_PIN_OFF: assert property (!readback_pin_enable_o && !$past(readback_pin_enable_o)
      |-> !gpio_oe_o) else $error("pin driven while readback off");
   AST_NACK_PAGE: assert property (pmb_valid_i && pmb_page_i != 8'hFF |=> pmb_nack_o)
      else $error("wrong page not refused");
   AST_NACK_OFF: assert property (pmb_valid_i && !pmbus_en_o && !$past(pmbus_en_o)
      && !$past(link_wr) |=> pmb_nack_o) else $error("paged command while disabled");
   AST_PROTECT: assert property (protect_input_sel_i && !gpio_i && $past(gpio_i)
      && !protect_busy_o && !mode[1] |-> ##[1:5] channel_hiz_o == 2'b11)
      else $error("protect power-down late");
   COV_ERR: cover property (reg_err_o);
   COV_NACK: cover property (pmb_nack_o);
   COV_HIZ: cover property (channel_hiz_o == 2'b11);
endmodule : ddc_config_regs_sva

// ==== dv/ddc_config_regs_bench.sv ====
// Self-checking bench of the configuration register group
`timescale 1ns/1ns
`define CHK(n, e, s) \
   begin \
      num_checks++; \
      if ((s) !== (e)) begin \
         mismatches++; \
         $display("CHECK FAILED %s expected %h seen %h", n, e, s); \
      end \
   end
module ddc_config_regs_bench;
   import ddc_pkg::*;
   typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} ddc_row_t;
   logic        clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_err_o, pmb_valid_i;
   logic        pmb_wr_i, pmb_nack_o, low_power_select_o, i2c_timeout_en_o, pmbus_en_o;
   logic        fast_readback_enable_o, readback_pin_enable_o, gpio_o, gpio_oe_o, nack;
   logic        gpio_i, protect_input_sel_i, sdo_active_i, sdo_data_i, protect_busy_o;
   logic [7:0]  reg_addr_i, pmb_page_i, pmb_cmd_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, d;
   logic [1:0]  channel_broadcast_enable_i, current_output_mode_i, channel_hiz_o;
   logic [23:0] nvm_code_i, margin_low_i, margin_high_i, channel_code_o;
   int          mismatches = 0, num_checks = 0, cyc = 0;
   ddc_row_t    rows [5] = '{'{8'h25, 16'h2300, 16'h2300}, '{8'h26, 16'hFFFF, 16'h1105},
      '{8'h2B, 16'hABCD, 16'h00CD}, '{8'h50, 16'hFFFF, 16'hFFF0}, '{8'h44, 16'h1234, 16'h0}};
   logic [7:0]  offs [4] = '{8'h25, 8'h26, 8'h2B, 8'h50};
   logic [1:0]  bcen [3] = '{2'b11, 2'b01, 2'b11};
   logic [15:0] bcd [3] = '{16'h1230, 16'hABCD, 16'h5A7F};
   logic [23:0] bce [3] = '{24'h123123, 24'h123ABC, 24'h5A05A7};
   logic [23:0] pend [4] = '{24'h400400, 24'h222111, 24'h3FC3FD, 24'h405404};
   logic [7:0]  pp [4] = '{8'hFF, 8'h03, 8'hFF, 8'hFF}, pc [4] = '{8'hE9, 8'hE9, 8'h00, 8'hF1};
   logic        pn [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   ddc_config_regs dut (.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
      .reg_rdata_o, .reg_rvalid_o, .reg_err_o, .pmb_valid_i, .pmb_wr_i, .pmb_page_i, .pmb_cmd_i,
      .pmb_wdata_i(reg_wdata_i), .pmb_nack_o, .low_power_select_o, .i2c_timeout_en_o,
      .pmbus_en_o, .fast_readback_enable_o, .readback_pin_enable_o, .gpio_i,
      .protect_input_sel_i, .sdo_active_i, .sdo_data_i, .gpio_o, .gpio_oe_o,
      .channel_broadcast_enable_i, .current_output_mode_i, .nvm_code_i, .margin_low_i,
      .margin_high_i, .channel_code_o, .channel_hiz_o, .protect_busy_o);
   ddc_host host (.clk_i, .rvalid_i(reg_rvalid_o), .rdata_i(reg_rdata_o), .nack_i(pmb_nack_o),
      .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i),
      .pv_o(pmb_valid_i), .pwr_o(pmb_wr_i), .page_o(pmb_page_i), .cmd_o(pmb_cmd_i));
   task complete_run;
      $display("num_checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      {reset_i, gpio_i, sdo_active_i, sdo_data_i} = 4'hF;
      {protect_input_sel_i, channel_broadcast_enable_i, current_output_mode_i} = '0;
      {nvm_code_i, margin_low_i, margin_high_i} = {24'h222111, 24'h3FC3FD, 24'h405404};
      repeat (12) @(posedge clk_i);
      `CHK("reset outputs", 5'h00, {pmbus_en_o, gpio_oe_o, channel_hiz_o, protect_busy_o})
      reset_i <= 1'b0;
      foreach (offs[i]) begin
         host.rd(offs[i], d);
         `CHK("reset value", 16'h0000, d)
      end
      foreach (rows[i]) begin
         host.wr(rows[i].a, rows[i].d);
         host.rd(rows[i].a, d);
         `CHK("register", rows[i].e, d)
      end
      `CHK("options", 5'h1F, {low_power_select_o, i2c_timeout_en_o, pmbus_en_o,
         fast_readback_enable_o, readback_pin_enable_o})
      `CHK("pin on", 2'b11, {gpio_oe_o, gpio_o})
      host.wr(8'h26, 16'h0000);
      repeat (3) @(posedge clk_i);
      `CHK("pin off", 1'b0, gpio_oe_o)
      host.wr(8'h2B, 16'h00FE);
      for (int i = 0; i < 3; i++) host.wr(8'h2C, 16'hA1A1 + 16'(i));
      host.rd(8'h2B, d);
      `CHK("pointer", 16'h0001, d)
      for (int i = 0; i < 3; i++) begin
         host.wr(8'h2B, 16'h00FE + 16'(i));
         host.rd(8'h2C, d);
         `CHK("word", 16'hA1A1 + 16'(i), d)
         host.rd(8'h2C, d);
         `CHK("word reread", 16'hA1A1 + 16'(i), d)
      end
      for (int i = 0; i < 3; i++) begin
         channel_broadcast_enable_i <= bcen[i];
         current_output_mode_i <= (i == 2) ? 2'b10 : 2'b00;
         host.wr(8'h50, bcd[i]);
         repeat (3) @(posedge clk_i);
         `CHK("codes", bce[i], channel_code_o)
      end
      host.cmd(8'hFF, 8'hE9, 16'h0300, nack);
      `CHK("paged disabled", 1'b1, nack)
      host.wr(8'h26, 16'h0100);
      for (int i = 0; i < 4; i++) begin
         host.cmd(pp[i], pc[i], 16'h2000, nack);
         `CHK("paged refusal", pn[i], nack)
      end
      host.rd(8'h25, d);
      `CHK("paged write", 16'h2000, d)
      `CHK("paged broadcast", 24'h200200, channel_code_o)
      protect_input_sel_i <= 1'b1;
      current_output_mode_i <= 2'b00;
      for (int m = 0; m < 4; m++) begin
         host.wr(8'h25, {6'h00, 2'(m), 8'h00});
         host.wr(8'h50, 16'h4000);
         repeat (3) @(posedge clk_i);
         `CHK("high level idle", 3'b000, {channel_hiz_o, protect_busy_o})
         gpio_i <= 1'b0;
         for (int k = 0; k < 40 && channel_hiz_o !== 2'b11; k++) @(posedge clk_i);
         `CHK("power-down", 3'b111, {channel_hiz_o, protect_busy_o})
         `CHK("final code", pend[m], channel_code_o)
         gpio_i <= 1'b1;
      end
      complete_run();
   end
endmodule : ddc_config_regs_bench
bind ddc_config_regs ddc_config_regs_sva chk (.clk_i, .reset_i, .reg_addr_i, .reg_wr_i,
   .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .reg_err_o, .pmb_valid_i, .pmb_page_i,
   .pmb_nack_o, .low_power_select_o, .i2c_timeout_en_o, .pmbus_en_o, .fast_readback_enable_o,
   .readback_pin_enable_o, .gpio_i, .protect_input_sel_i, .gpio_oe_o, .channel_hiz_o,
   .protect_busy_o);
